// ===== pkg/conv_map.svh
/*
  Named constants of the converter control block: result word layout,
  cycle counts and buffer depth.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef CONV_MAP_SVH
`define CONV_MAP_SVH

`define RES_W 16
`define MSB_W 10
`define LSB_W 6
`define DIAG_W 2
`define CONV_CYCLES 17
`define CAL_CYCLES 85530
`define CNT_W 17
`define BUF_DEPTH 2

`endif

// ===== pkg/conv_pkg.sv
/*
  Types of the converter control block: controller states and the state record.
  Assumes conv_map.svh is on the include path.
*/
`include "conv_map.svh"

package conv_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CONV = 3'b001,
    ST_PUSH = 3'b010,
    ST_CAL = 3'b011,
    ST_FINISH = 3'b100
  } ctrl_state_type;

  typedef struct packed {
    ctrl_state_type st;
    logic [`CNT_W-1:0] cnt;
    logic acq_s1;
    logic acq_s2;
    logic acq_s3;
    logic busy;
    logic track;
    logic pend;
    logic [`RES_W-1:0] held;
    logic [`RES_W-1:0] res;
    logic res_valid;
  } ctrl_regs_type;

endpackage

// ===== pkg/conv_if.sv
/*
  Word link between the converter controller and its result buffer.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps

interface conv_if #(
  parameter int WIDTH = 16
);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;

  modport buf_side (
    input in_valid,
    input in_data,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport ctrl_side (
    output in_valid,
    output in_data,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_data
  );
endinterface

// ===== rtl/pair_buffer.sv
/*
  Small result buffer of DEPTH words with valid and ready on both sides.
  Assumes one clock; flush clears it synchronously.
*/
`timescale 1ns/10ps

module pair_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  // Clock and control.
  input wire logic core_clk,
  input wire logic flush,
  input wire logic clk_en,
  // Word link.
  conv_if.buf_side link
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } buf_regs_type;

  buf_regs_type b_q;
  buf_regs_type b_d;
  logic push;
  logic pop;

  assign link.in_ready = b_q.count != CW'(DEPTH);
  assign link.out_valid = b_q.count != '0;
  assign link.out_data = b_q.mem[b_q.rd_ptr];
  assign push = link.in_valid && link.in_ready;
  assign pop = link.out_valid && link.out_ready;

  always_comb begin
    b_d = b_q;
    if (push) begin
      b_d.mem[b_q.wr_ptr] = link.in_data;
      b_d.wr_ptr = (b_q.wr_ptr == PW'(DEPTH - 1)) ? '0 : b_q.wr_ptr + PW'(1);
    end
    if (pop) begin
      b_d.rd_ptr = (b_q.rd_ptr == PW'(DEPTH - 1)) ? '0 : b_q.rd_ptr + PW'(1);
    end
    if (push && !pop) begin
      b_d.count = b_q.count + CW'(1);
    end else if (pop && !push) begin
      b_d.count = b_q.count - CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (flush) begin
      b_q <= '0;
    end else if (clk_en) begin
      b_q <= b_d;
    end
  end

  AST_BUF_NO_OVERFLOW: assert property (@(posedge core_clk) disable iff (flush) // see R12
    b_q.count <= CW'(DEPTH))
    else $error("Buffer accepts a word while full.");

  AST_BUF_PUSH_COUNT: assert property (@(posedge core_clk) disable iff (flush) // see R12
    (clk_en && push && !pop) |=> (b_q.count == $past(b_q.count) + CW'(1)))
    else $error("Buffer count did not grow on a push.");
endmodule

// ===== rtl/conv_ctrl.sv
/*
  Digital control of a 16-bit sampling converter: acquisition edge start,
  conversion timing, calibration sequencing, busy status and the split result word.
  Assumes analog_code and result_take come from logic on core_clk, acq_in and
  cal_req come from pins.
*/
// Operation
// R1 - The result is shown as ten upper lines and six separate lower lines.
// R2 - Busy is high while a conversion or a calibration runs and low otherwise; the code keeps it high in ST_PUSH until the buffer takes the word.
// R3 - The acquisition input is active high and makes the sample-hold track while high; the code holds sh_track low in ST_CAL.
// R4 - A falling edge of the acquisition input starts the conversion of the held sample.
// R5 - The host supplies seventeen clock cycles for each conversion.
// R6 - The host keeps the acquisition input low during calibration.
// R7 - With the acquisition input high during calibration the two lowest lines show diagnostics.
// R8 - The calibration request acts without regard to the clock.
// R9 - A high calibration request resets the control, aborts any work and raises busy.
// R10 - Calibration starts when the request falls and ends after 85530 cycles as busy falls.
// R11 - The host gives one more clock cycle after busy falls at the end of calibration.
// R12 - The result lines stay stable from the end of a conversion until the next result loads.
`timescale 1ns/10ps
`include "conv_map.svh"

module conv_ctrl
  import conv_pkg::*;
#(
  parameter int CONV_CYCLES = `CONV_CYCLES,
  parameter int CAL_CYCLES = `CAL_CYCLES
) (
  // Clock, reset and enable.
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Control pins.
  input wire logic acq_in,
  input wire logic cal_req,
  // Analog side and result drain.
  input wire logic [`RES_W-1:0] analog_code,
  input wire logic result_take,
  // Status and result.
  output logic busy,
  output logic sh_track,
  output logic result_valid,
  output logic [`MSB_W-1:0] result_msb,
  output logic [`LSB_W-1:0] result_lsb
);
  localparam int CW = `CNT_W;
  localparam ctrl_regs_type CAL_RESET = '{st: ST_CAL, busy: 1'b1, default: '0};
  localparam ctrl_regs_type IDLE_RESET = '{st: ST_IDLE, default: '0};

  ctrl_regs_type r_q;
  ctrl_regs_type r_d;
  logic cal_r1_q;
  logic cal_rst_q;
  logic acq_fall;
  logic buf_flush;

  conv_if #(.WIDTH(`RES_W)) buf_link ();

  assign buf_flush = srst || cal_rst_q;

  pair_buffer #(
    .WIDTH(`RES_W),
    .DEPTH(`BUF_DEPTH)
  ) u_buf (
    .core_clk(core_clk),
    .flush(buf_flush),
    .clk_en(clk_en),
    .link(buf_link.buf_side)
  );

  // The calibration request is seen at once and released on the clock.
  always_ff @(posedge core_clk or posedge cal_req) begin // see R8
    if (cal_req) begin
      cal_r1_q <= 1'b1;
      cal_rst_q <= 1'b1;
    end else if (clk_en) begin
      cal_r1_q <= 1'b0;
      cal_rst_q <= cal_r1_q;
    end
  end

  assign acq_fall = r_q.acq_s3 && !r_q.acq_s2;

  always_comb begin
    r_d = r_q;
    buf_link.in_valid = 1'b0;
    buf_link.in_data = r_q.held;
    buf_link.out_ready = !r_q.res_valid || result_take;
    r_d.acq_s1 = acq_in;
    r_d.acq_s2 = r_q.acq_s1;
    r_d.acq_s3 = r_q.acq_s2;
    r_d.track = r_q.acq_s2 && (r_q.st != ST_CAL); // see R3
    unique case (r_q.st)
      ST_IDLE: begin
        if (acq_fall || r_q.pend) begin // see R4
          r_d.st = ST_CONV;
          r_d.cnt = '0;
          r_d.busy = 1'b1; // see R2
          r_d.held = analog_code;
          r_d.pend = 1'b0;
        end
      end
      ST_CONV: begin
        if (r_q.cnt == CW'(CONV_CYCLES - 1)) begin // see R5
          r_d.st = ST_PUSH;
        end else begin
          r_d.cnt = r_q.cnt + CW'(1);
        end
      end
      ST_PUSH: begin
        buf_link.in_valid = 1'b1;
        if (buf_link.in_ready) begin
          r_d.st = ST_IDLE;
          r_d.busy = 1'b0; // see R2
        end
      end
      ST_CAL: begin
        if (r_q.acq_s2) begin // see R7
          r_d.res[`DIAG_W-1:0] = r_q.cnt[`DIAG_W-1:0];
        end
        if (r_q.cnt == CW'(CAL_CYCLES - 1)) begin // see R10
          r_d.st = ST_FINISH;
          r_d.busy = 1'b0;
        end else begin
          r_d.cnt = r_q.cnt + CW'(1);
        end
      end
      ST_FINISH: begin
        r_d.st = ST_IDLE; // see R11
        if (acq_fall) begin
          r_d.pend = 1'b1;
        end
      end
      default: begin
        r_d.st = ST_IDLE;
        r_d.busy = 1'b0;
      end
    endcase
    if (buf_link.out_valid && buf_link.out_ready) begin // see R12
      r_d.res = buf_link.out_data;
      r_d.res_valid = 1'b1;
    end else if (result_take) begin
      r_d.res_valid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge cal_rst_q) begin
    if (cal_rst_q) begin
      r_q <= CAL_RESET; // see R9
    end else if (srst) begin
      r_q <= IDLE_RESET;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign busy = r_q.busy;
  assign sh_track = r_q.track;
  assign result_valid = r_q.res_valid;
  assign result_msb = r_q.res[`RES_W-1:`LSB_W]; // see R1
  assign result_lsb = r_q.res[`LSB_W-1:0]; // see R1

  sequence seq_conv_start;
    clk_en && (r_q.st == ST_IDLE) && acq_fall;
  endsequence

  sequence seq_conv_last;
    clk_en && (r_q.st == ST_CONV) && (r_q.cnt == CW'(CONV_CYCLES - 1));
  endsequence

  sequence seq_cal_last;
    clk_en && (r_q.st == ST_CAL) && (r_q.cnt == CW'(CAL_CYCLES - 1));
  endsequence

  AST_CAL_RAISES_BUSY: assert property (@(posedge core_clk) disable iff (srst) // see R9
    cal_rst_q |-> (busy && (r_q.st == ST_CAL) && (r_q.cnt == '0)))
    else $error("Calibration request did not reset the control with busy high.");

  AST_FALL_STARTS: assert property (@(posedge core_clk) // see R4
    disable iff (srst || cal_rst_q)
    seq_conv_start |=> (busy && (r_q.st == ST_CONV) && (r_q.held == $past(analog_code))))
    else $error("Acquisition fall did not start a conversion.");

  AST_CONV_LENGTH: assert property (@(posedge core_clk) // see R5
    disable iff (srst || cal_rst_q)
    seq_conv_last |=> (r_q.st == ST_PUSH) && busy)
    else $error("Conversion did not end after its cycle count.");

  AST_IDLE_NOT_BUSY: assert property (@(posedge core_clk) // see R2
    disable iff (srst || cal_rst_q)
    (r_q.st == ST_IDLE) |-> !busy)
    else $error("Busy high while idle.");

  AST_CAL_END: assert property (@(posedge core_clk) // see R10
    disable iff (srst || cal_rst_q)
    seq_cal_last |=> (!busy && (r_q.st == ST_FINISH))
      ##1 ((r_q.st == ST_IDLE) || !$past(clk_en)))
    else $error("Calibration did not end with busy low and one finishing cycle.");

  AST_DIAG_LINES: assert property (@(posedge core_clk) // see R7
    disable iff (srst || cal_rst_q)
    (clk_en && (r_q.st == ST_CAL) && r_q.acq_s2)
      |=> (result_lsb[`DIAG_W-1:0] == $past(r_q.cnt[`DIAG_W-1:0])))
    else $error("Diagnostic lines do not follow calibration progress.");

  AST_RESULT_STABLE: assert property (@(posedge core_clk) // see R12
    disable iff (srst || cal_rst_q)
    ((r_q.st != ST_CAL) && !(buf_link.out_valid && buf_link.out_ready))
      |=> $stable({result_msb, result_lsb}))
    else $error("Result lines changed without a new result.");

  AST_TRACK_LEVEL: assert property (@(posedge core_clk) // see R3
    disable iff (srst || cal_rst_q)
    (clk_en && (r_q.st != ST_CAL)) |=> (sh_track == $past(r_q.acq_s2)))
    else $error("Sample-hold track does not follow the acquisition level.");
endmodule

// ===== bench/host_drain.sv
/*
  Host model that drains result words from the converter control block.
  Assumes the bench drives stall and that the clock runs free.
*/
`timescale 1ns/10ps

module host_drain (
  // Clock.
  input wire logic core_clk,
  // Drain control.
  input wire logic stall,
  input wire logic result_valid,
  output logic result_take
);
  // The clock never stops, so every conversion and the cycle after calibration get clocks.
  initial result_take = 1'b0;
  always @(negedge core_clk) begin
    result_take <= result_valid & ~stall;
  end
endmodule

// ===== bench/sampling_converter_control_tb.sv
/*
  Self-checking bench of the converter control block.
  Assumes conv_map.svh on the include path and a free running host clock.
*/
`timescale 1ns/10ps
`include "conv_map.svh"
`define CHK(nm, ex, gt) cmp_count++; if ((gt) !== (ex)) begin \
  err_total++; $display("wrong value %s exp %h got %h", nm, ex, gt); end

module sampling_converter_control_tb;
  import conv_pkg::*;
  localparam int CAL_N = 20;
  logic core_clk, srst, acq_in, cal_req, stall, result_take, clk_en;
  logic [`RES_W-1:0] analog_code;
  logic busy, sh_track, result_valid;
  logic [`MSB_W-1:0] result_msb;
  logic [`LSB_W-1:0] result_lsb;
  logic [`RES_W-1:0] w;
  int err_total, cmp_count;

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  conv_ctrl #(.CAL_CYCLES(CAL_N)) conv_ctrl_inst (
    .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .acq_in(acq_in), .cal_req(cal_req),
    .analog_code(analog_code), .result_take(result_take), .busy(busy), .sh_track(sh_track),
    .result_valid(result_valid), .result_msb(result_msb), .result_lsb(result_lsb));

  host_drain host_drain_inst (.core_clk(core_clk), .stall(stall),
    .result_valid(result_valid), .result_take(result_take));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic give_up(input string nm);
    err_total++;
    $display("wrong value %s exp done got stuck", nm);
    tally_and_finish();
  endtask

  task automatic wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy !== lvl) begin
      @(negedge core_clk);
      n++;
      if (n > 200) begin
        give_up("busy wait");
      end
    end
  endtask

  task automatic start_conv(input logic [15:0] code, input logic done);
    int n;
    analog_code = code;
    acq_in = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK("track", 1'b1, sh_track)
    acq_in = 1'b0;
    wait_busy(1'b1, n);
    `CHK("hold", 1'b0, sh_track)
    if (done) begin
      wait_busy(1'b0, n);
      `CHK("conv length", 1'b1, n >= 17)
      @(negedge core_clk);
    end
  endtask

  task automatic drain(input logic [15:0] q[$]);
    int n;
    stall <= 1'b0;
    for (n = 0; q.size() > 0; n++) begin
      @(negedge core_clk);
      if (result_valid === 1'b1) begin
        `CHK("word", q[0], {result_msb, result_lsb})
        void'(q.pop_front());
      end
      if (n > 80) begin
        give_up("drain");
      end
    end
    stall <= 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("drained", 1'b0, result_valid)
  endtask

  task automatic pulse_cal(input logic acq_hi);
    int n;
    logic [1:0] d1;
    cal_req = 1'b1;
    #1 `CHK("busy async", 1'b1, busy)
    @(negedge core_clk);
    cal_req = 1'b0;
    acq_in = acq_hi;
    repeat (6) @(negedge core_clk);
    d1 = result_lsb[1:0];
    @(negedge core_clk);
    `CHK("diag upper", 14'h0000, {result_msb, result_lsb[5:2]})
    `CHK("diag moves", acq_hi, d1 !== result_lsb[1:0])
    acq_in = 1'b0;
    wait_busy(1'b0, n);
    `CHK("cal length", 1'b1, (n + 7 >= CAL_N) && (n + 7 <= CAL_N + 4))
    repeat (4) @(negedge core_clk);
    `CHK("idle busy", 1'b0, busy)
    $display("calibration test done");
  endtask

  task automatic t_sequence;
    start_conv(16'h8001, 1'b1);
    start_conv(16'h7ffe, 1'b1);
    start_conv(16'h0040, 1'b1);
    w = {result_msb, result_lsb};
    repeat (10) @(negedge core_clk);
    `CHK("stable", 16'h8001, {result_msb, result_lsb})
    `CHK("stable again", w, {result_msb, result_lsb})
    start_conv(16'hffff, 1'b0);
    repeat (40) @(negedge core_clk);
    `CHK("full busy", 1'b1, busy)
    drain('{16'h8001, 16'h7ffe, 16'h0040, 16'hffff});
    `CHK("after drain", 1'b0, busy)
    $display("sequence test done");
  endtask

  task automatic t_abort;
    start_conv(16'h1234, 1'b0);
    repeat (5) @(negedge core_clk);
    pulse_cal(1'b0);
    `CHK("aborted word", 1'b0, result_valid)
    start_conv(16'h0abc, 1'b1);
    drain('{16'h0abc});
    $display("abort test done");
  endtask

  task automatic t_freeze;
    int n;
    start_conv(16'h5a5a, 1'b0);
    clk_en = 1'b0;
    repeat (30) @(negedge core_clk);
    `CHK("frozen busy", 1'b1, busy)
    `CHK("frozen valid", 1'b0, result_valid)
    clk_en = 1'b1;
    wait_busy(1'b0, n);
    `CHK("frozen length", 1'b1, n >= 17)
    @(negedge core_clk);
    drain('{16'h5a5a});
    $display("freeze test done");
  endtask

  initial begin
    err_total = 0;
    cmp_count = 0;
    srst = 1'b1;
    clk_en = 1'b1;
    acq_in = 1'b0;
    cal_req = 1'b0;
    stall = 1'b1;
    analog_code = 16'h0000;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset valid", 1'b0, result_valid)
    $display("reset test done");
    pulse_cal(1'b1);
    t_sequence();
    t_abort();
    t_freeze();
    tally_and_finish();
  end
endmodule
